// [hppc_partner.sv]
// Far-side model: port power switches with current monitors, the charge
// controller alert line and a serial configuration ROM.
// Assumes the bench commands faults and alerts; the ROM runs in mode 0.
module hppc_partner
#(
   parameter logic [7:0] ROM_BYTE = 8'h96
)
(
   input  wire logic       i_ce_n,
   input  wire logic       i_sck,
   input  wire logic       i_mosi,
   input  wire logic [3:0] i_pwr,
   input  wire logic [3:0] i_fault,
   input  wire logic       i_alert_req,
   output logic [3:0]      o_oc,
   output logic            o_alert_n,
   output logic            o_miso,
   output logic [7:0]      o_rx
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [3:0] nrx;
   logic [3:0] nsh;

   // A monitor flags over-current only on a powered port.
   assign o_oc = i_pwr & i_fault;
   // The charge controller pulls its alert line low to ask for service.
   assign o_alert_n = ~i_alert_req;

   // The ROM takes a bit on each rising clock while it is enabled.
   always @(posedge i_sck or posedge i_ce_n)
      if (i_ce_n)
         nrx <= 4'h0;
      else
      begin
         nrx  <= nrx + 4'h1;
         o_rx <= {o_rx[6:0], i_mosi};
      end

   // The ROM moves to its next output bit on each falling clock.
   always @(negedge i_sck or posedge i_ce_n)
      if (i_ce_n)
         nsh <= 4'h0;
      else
         nsh <= nrx;

   // The data line falls to its pull-down level while the ROM is idle.
   assign o_miso = i_ce_n ? 1'b0 : ROM_BYTE[3'd7 - nsh[2:0]];
endmodule : hppc_partner

// [hppc_pkg.sv]
// Package for the hub port power and charge pin logic: register map, field layout,
// reset values and timing constants.
// Assumes one 20 MHz clock and an APB master with 32-bit data.
package hppc_pkg;

   // ------------------------------------------------------------------------
   // Register byte addresses.
   // ------------------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL      = 8'h00;
   localparam logic [7:0] ADDR_STATUS    = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT  = 8'h08;
   localparam logic [7:0] ADDR_IRQ_CLR   = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_EN    = 8'h10;
   localparam logic [7:0] ADDR_ROM_CMD   = 8'h14;
   localparam logic [7:0] ADDR_ROM_DATA  = 8'h18;

   // ------------------------------------------------------------------------
   // Field positions.
   // ------------------------------------------------------------------------
   localparam int CTRL_PWR_LSB    = 0;  // Port power enables, four bits.
   localparam int CTRL_CHG_LSB    = 4;  // Charging port configuration, four bits.
   localparam int CTRL_SMB_BIT    = 8;  // SMBus configuration interface in use.
   localparam int CTRL_PUEN_BIT   = 9;  // Software permits the D+ connect.
   localparam int STAT_OC_LSB     = 0;  // Synchronised over-current levels.
   localparam int STAT_CHG_LSB    = 4;  // Charging actually active per port.
   localparam int STAT_VBUS_BIT   = 8;
   localparam int STAT_PU_BIT     = 9;
   localparam int STAT_LEGACY_BIT = 10;
   localparam int STAT_ALERT_BIT  = 11;
   localparam int STAT_DIS_BIT    = 12;
   localparam int STAT_BUSY_BIT   = 13;
   // Interrupt status layout.
   localparam int IRQ_OC_LSB      = 0;  // Over-current rise per port.
   localparam int IRQ_VBUS_BIT    = 4;  // Bus power changed.
   localparam int IRQ_ALERT_BIT   = 5;  // Charger alert asserted.
   localparam int IRQ_DIS_BIT     = 6;  // Charging disable changed.
   localparam int IRQ_ROM_BIT     = 7;  // ROM byte transfer done.
   localparam int IRQ_W           = 8;
   // ROM command layout: bit 8 starts a byte, bit 9 holds chip enable low.
   localparam int ROM_GO_BIT      = 8;
   localparam int ROM_HOLD_BIT    = 9;

   // ------------------------------------------------------------------------
   // Reset values and timing.
   // ------------------------------------------------------------------------
   localparam logic [9:0] CTRL_RST  = 10'h000;
   localparam int         CLK_HZ    = 20_000_000;
   localparam int         ROM_HZ    = 1_000_000;  // Serial ROM clock rate.
   localparam int         ROM_HALF  = CLK_HZ / (2 * ROM_HZ);
   localparam int         NPORT     = 4;

   // ROM shifter states.
   typedef enum logic [2:0]
   {
      ROM_IDLE  = 3'b001,
      ROM_SHIFT = 3'b010,
      ROM_DONE  = 3'b100
   } hppc_rom_e;

endpackage : hppc_pkg

// [hppc_rom.sv]
// Byte shifter toward an external serial configuration ROM, mode 0, MSB first.
// Assumes a start pulse from the register block on the same clock.
module hppc_rom
   import hppc_pkg::*;
#(
   parameter int HALF = ROM_HALF
)
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_start,
   input  wire logic       i_hold,
   input  wire logic [7:0] i_tx,
   input  wire logic       i_miso,
   output logic            o_ce_n,
   output logic            o_sck,
   output logic            o_mosi,
   output logic [7:0]      o_rx,
   output logic            o_busy,
   output logic            o_done
);

   // ------------------------------------------------------------------------
   // Shift engine.
   // ------------------------------------------------------------------------
   hppc_rom_e   state_r;
   logic [7:0]  sh_r;
   logic [3:0]  bit_r;
   logic [7:0]  div_r;
   logic        sck_r;
   logic        ce_n_r;
   logic [1:0]  miso_s_r;

   // Data input comes from a pin, so it is synchronised first.
   always_ff @(posedge i_clk)
   begin
      if (i_rst) miso_s_r <= 2'h0;
      else       miso_s_r <= {miso_s_r[0], i_miso};
   end

   // Chip enable falls for a byte and rises after unless held for a burst.
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         state_r <= ROM_IDLE;
         sh_r    <= 8'h00;
         bit_r   <= 4'h0;
         div_r   <= 8'h00;
         sck_r   <= 1'b0;
         ce_n_r  <= 1'b1;
         o_rx    <= 8'h00;
      end
      else
      begin
         unique case (state_r)
            ROM_IDLE:
            begin
               if (i_start)
               begin
                  state_r <= ROM_SHIFT;
                  sh_r    <= i_tx;
                  bit_r   <= 4'h0;
                  div_r   <= 8'h00;
                  ce_n_r  <= 1'b0;
               end
               else if (!i_hold) ce_n_r <= 1'b1;
            end
            ROM_SHIFT:
            begin
               if (div_r == 8'(HALF - 1))
               begin
                  div_r <= 8'h00;
                  sck_r <= ~sck_r;
                  if (!sck_r) o_rx <= {o_rx[6:0], miso_s_r[1]};
                  else
                  begin
                     sh_r  <= {sh_r[6:0], 1'b0};
                     bit_r <= bit_r + 4'h1;
                     if (bit_r == 4'h7) state_r <= ROM_DONE;
                  end
               end
               else div_r <= div_r + 8'h01;
            end
            ROM_DONE:
            begin
               state_r <= ROM_IDLE;
               if (!i_hold) ce_n_r <= 1'b1;
            end
            default: state_r <= ROM_IDLE;
         endcase
      end
   end

   assign o_ce_n = ce_n_r;
   assign o_sck  = sck_r;
   assign o_mosi = sh_r[7];
   assign o_busy = (state_r != ROM_IDLE);
   assign o_done = (state_r == ROM_DONE);

   // ------------------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------------------
   property p_ce_low_shift;
      @(posedge i_clk) disable iff (i_rst)
      (state_r == ROM_SHIFT) |-> !o_ce_n;
   endproperty
   a_ce_low_shift: assert property (p_ce_low_shift)
      else $error("ROM enable high during a shift.");

   property p_done_once;
      @(posedge i_clk) disable iff (i_rst)
      o_done |=> !o_done;
   endproperty
   a_done_once: assert property (p_done_once)
      else $error("ROM done lasted more than a cycle.");

   c_rom_byte: cover property (@(posedge i_clk) disable iff (i_rst) o_done);

endmodule : hppc_rom

// [hppc_top.sv]
// Top of the hub port power and charge pin logic with its APB register file.
// Assumes an APB master on I_CLK; pin inputs arrive asynchronously.
//
// Local design decisions: the APB interface to the registers and the register offsets.
module hppc_top
   import hppc_pkg::*;
#(
   parameter int N = NPORT
)
(
   input  wire logic          I_CLK,
   input  wire logic          I_SYS_RST,
   // APB slave.
   input  wire logic          I_PSEL,
   input  wire logic          I_PENABLE,
   input  wire logic          I_PWRITE,
   input  wire logic [7:0]    I_PADDR,
   input  wire logic [31:0]   I_PWDATA,
   output logic [31:0]        O_PRDATA,
   output logic               O_PREADY,
   output logic               O_PSLVERR,
   // Port pins.
   output logic [N-1:0]       O_PORT_POWER_ENABLE,
   input  wire logic [N-1:0]  I_OVERCURRENT_SENSE,
   output logic [N-1:0]       O_CHARGE_ACTIVE,
   input  wire logic          I_BUS_POWER_DETECT,
   output logic               O_DP_PULLUP_EN,
   input  wire logic          I_JTAG_RESET_STRAP,
   output logic               O_LEGACY_MODE,
   input  wire logic          I_CHARGING_DISABLE_N,
   input  wire logic          I_CHARGER_ALERT_N,
   // Serial configuration ROM.
   output logic               O_ROM_ENABLE_N,
   output logic               O_ROM_CLK,
   output logic               O_ROM_SERIAL_OUT,
   input  wire logic          I_ROM_SERIAL_IN,
   output logic               O_IRQ
);

   // ------------------------------------------------------------------------
   // Pin synchronisers.
   // ------------------------------------------------------------------------
   logic [N+2:0] meta_r;
   logic [N+2:0] sync_r;
   logic [N+2:0] prev_r;
   logic         vbus;
   logic         alert;
   logic         chg_dis;
   logic [N-1:0] oc;

   // Bus power, alert, disable and over-current levels pass two flops.
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         meta_r <= '0;
         sync_r <= '0;
         prev_r <= '0;
      end
      else
      begin
         meta_r <= {I_BUS_POWER_DETECT, ~I_CHARGER_ALERT_N, ~I_CHARGING_DISABLE_N,
                    I_OVERCURRENT_SENSE};
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign vbus    = sync_r[N+2];
   assign alert   = sync_r[N+1];
   assign chg_dis = sync_r[N];
   assign oc      = sync_r[N-1:0];

   // ------------------------------------------------------------------------
   // Registers.
   // ------------------------------------------------------------------------
   logic [9:0]        ctrl_r;
   logic [IRQ_W-1:0]  irq_stat_r;
   logic [IRQ_W-1:0]  irq_en_r;
   logic [IRQ_W-1:0]  irq_set;
   logic [7:0]        rom_tx_r;
   logic              rom_hold_r;
   logic              rom_go_r;
   logic              legacy_r;
   logic              strap_done_r;
   logic [1:0]        strap_cnt_r;
   logic [1:0]        strap_s_r;
   logic              wr_en;
   logic              rd_en;
   logic              rom_busy;
   logic              rom_done;
   logic [7:0]        rom_rx;
   logic [31:0]       status;
   logic              addr_ok;

   // Every access finishes in its first access cycle.
   assign wr_en = I_PSEL & I_PENABLE & I_PWRITE;
   assign rd_en = I_PSEL & I_PENABLE & ~I_PWRITE;

   // Address decode used by the error logic; the read path decodes the address on its own.
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_IRQ_STAT) ||
               (a == ADDR_IRQ_CLR) || (a == ADDR_IRQ_EN) || (a == ADDR_ROM_CMD) ||
               (a == ADDR_ROM_DATA);
   endfunction : mapped

   assign addr_ok = mapped(I_PADDR);

   // Control register holds power enables, charging ports and mode bits.
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST) ctrl_r <= CTRL_RST;
      else if (wr_en && I_PADDR == ADDR_CTRL) ctrl_r <= I_PWDATA[9:0];
   end

   // Enable register for the interrupt.
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST) irq_en_r <= '0;
      else if (wr_en && I_PADDR == ADDR_IRQ_EN) irq_en_r <= I_PWDATA[IRQ_W-1:0];
   end

   // ROM command: data byte, start pulse and burst hold.
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         rom_tx_r   <= 8'h00;
         rom_hold_r <= 1'b0;
         rom_go_r   <= 1'b0;
      end
      else
      begin
         rom_go_r <= 1'b0;
         if (wr_en && I_PADDR == ADDR_ROM_CMD)
         begin
            rom_tx_r   <= I_PWDATA[7:0];
            rom_hold_r <= I_PWDATA[ROM_HOLD_BIT];
            rom_go_r   <= I_PWDATA[ROM_GO_BIT] & ~rom_busy;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Strap capture after reset release.
   // ------------------------------------------------------------------------
   // The strap passes two flops; it is caught once from the second flop, on the third clock after reset release.
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         strap_s_r    <= 2'h0;
         strap_cnt_r  <= 2'h0;
         strap_done_r <= 1'b0;
         legacy_r     <= 1'b0;
      end
      else
      begin
         strap_s_r <= {strap_s_r[0], I_JTAG_RESET_STRAP};
         if (!strap_done_r)
         begin
            strap_cnt_r <= strap_cnt_r + 2'h1;
            if (strap_cnt_r == 2'h2)
            begin
               strap_done_r <= 1'b1;
               legacy_r     <= strap_s_r[1];
            end
         end
      end
   end

   // Legacy mode applies only while the SMBus configuration is in use.
   assign O_LEGACY_MODE = legacy_r & ctrl_r[CTRL_SMB_BIT];

   // ------------------------------------------------------------------------
   // Port outputs.
   // ------------------------------------------------------------------------
   logic [N-1:0] pwr_r;
   logic [N-1:0] chg_r;
   logic         pu_r;

   // Outputs come from flops; charging drops on every port together.
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         pwr_r <= '0;
         chg_r <= '0;
         pu_r  <= 1'b0;
      end
      else
      begin
         pwr_r <= ctrl_r[CTRL_PWR_LSB +: N];
         chg_r <= chg_dis ? '0 : ctrl_r[CTRL_CHG_LSB +: N];
         pu_r  <= vbus & ctrl_r[CTRL_PUEN_BIT];
      end
   end

   assign O_PORT_POWER_ENABLE = pwr_r;
   assign O_CHARGE_ACTIVE     = chg_r;
   assign O_DP_PULLUP_EN      = pu_r;

   // ------------------------------------------------------------------------
   // Interrupts.
   // ------------------------------------------------------------------------
   assign irq_set[IRQ_OC_LSB +: N]  = oc & ~prev_r[N-1:0];
   assign irq_set[IRQ_VBUS_BIT]     = sync_r[N+2] ^ prev_r[N+2];
   assign irq_set[IRQ_ALERT_BIT]    = sync_r[N+1] & ~prev_r[N+1];
   assign irq_set[IRQ_DIS_BIT]      = sync_r[N] ^ prev_r[N];
   assign irq_set[IRQ_ROM_BIT]      = rom_done;

   // Sticky status; a new event wins over a clear in the same cycle.
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST) irq_stat_r <= '0;
      else if (wr_en && I_PADDR == ADDR_IRQ_CLR)
         irq_stat_r <= (irq_stat_r & ~I_PWDATA[IRQ_W-1:0]) | irq_set;
      else
         irq_stat_r <= irq_stat_r | irq_set;
   end

   assign O_IRQ = |(irq_stat_r & irq_en_r);

   // ------------------------------------------------------------------------
   // Read path.
   // ------------------------------------------------------------------------
   always_comb
   begin
      status = '0;
      status[STAT_OC_LSB +: N]  = oc;
      status[STAT_CHG_LSB +: N] = chg_r;
      status[STAT_VBUS_BIT]     = vbus;
      status[STAT_PU_BIT]       = pu_r;
      status[STAT_LEGACY_BIT]   = legacy_r;
      status[STAT_ALERT_BIT]    = alert;
      status[STAT_DIS_BIT]      = chg_dis;
      status[STAT_BUSY_BIT]     = rom_busy;
   end

   // Read data is registered and appears with pready.
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST) O_PRDATA <= 32'h0000_0000;
      else if (I_PSEL && !I_PENABLE && !I_PWRITE)
      begin
         unique case (I_PADDR)
            ADDR_CTRL:     O_PRDATA <= {22'h0, ctrl_r};
            ADDR_STATUS:   O_PRDATA <= status;
            ADDR_IRQ_STAT: O_PRDATA <= {24'h0, irq_stat_r};
            ADDR_IRQ_EN:   O_PRDATA <= {24'h0, irq_en_r};
            ADDR_ROM_CMD:  O_PRDATA <= {22'h0, rom_hold_r, 1'b0, rom_tx_r};
            ADDR_ROM_DATA: O_PRDATA <= {24'h0, rom_rx};
            default:       O_PRDATA <= 32'h0000_0000;
         endcase
      end
   end

   assign O_PREADY  = 1'b1;
   assign O_PSLVERR = I_PSEL & I_PENABLE & ~addr_ok;

   // ------------------------------------------------------------------------
   // Serial ROM master.
   // ------------------------------------------------------------------------
   hppc_rom #(.HALF(ROM_HALF)) u_rom
   (
      .i_clk  (I_CLK),
      .i_rst  (I_SYS_RST),
      .i_start(rom_go_r),
      .i_hold (rom_hold_r),
      .i_tx   (rom_tx_r),
      .i_miso (I_ROM_SERIAL_IN),
      .o_ce_n (O_ROM_ENABLE_N),
      .o_sck  (O_ROM_CLK),
      .o_mosi (O_ROM_SERIAL_OUT),
      .o_rx   (rom_rx),
      .o_busy (rom_busy),
      .o_done (rom_done)
   );

   // ------------------------------------------------------------------------
   // Checks.
   // ------------------------------------------------------------------------
   property p_pullup_needs_vbus;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      O_DP_PULLUP_EN |-> $past(vbus);
   endproperty
   a_pullup_needs_vbus: assert property (p_pullup_needs_vbus)
      else $error("D+ pull-up on without bus power.");

   property p_vbus_sync;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      $rose(I_BUS_POWER_DETECT) ##1 I_BUS_POWER_DETECT[*2] |-> vbus;
   endproperty
   a_vbus_sync: assert property (p_vbus_sync)
      else $error("Bus power not seen two cycles after the pin.");

   property p_charge_off;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      chg_dis |=> (O_CHARGE_ACTIVE == '0);
   endproperty
   a_charge_off: assert property (p_charge_off)
      else $error("Charging active while disabled.");

   property p_power_follows;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      1'b1 |=> (O_PORT_POWER_ENABLE == $past(ctrl_r[N-1:0]));
   endproperty
   a_power_follows: assert property (p_power_follows)
      else $error("Port power does not follow control.");

   property p_alert_irq;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      $rose(alert) |=> irq_stat_r[IRQ_ALERT_BIT];
   endproperty
   a_alert_irq: assert property (p_alert_irq)
      else $error("Charger alert not latched.");

   property p_strap_held;
      @(posedge I_CLK) disable iff (I_SYS_RST)
      strap_done_r |=> $stable(legacy_r);
   endproperty
   a_strap_held: assert property (p_strap_held)
      else $error("Legacy strap changed after capture.");

   c_pullup:  cover property (@(posedge I_CLK) disable iff (I_SYS_RST) $rose(O_DP_PULLUP_EN));
   c_chg_off: cover property (@(posedge I_CLK) disable iff (I_SYS_RST) $fell(|O_CHARGE_ACTIVE));
   c_irq:     cover property (@(posedge I_CLK) disable iff (I_SYS_RST) $rose(O_IRQ));

endmodule : hppc_top

// [test_hppc_top.sv]
// Self-checking bench for the hub port power and charge pin logic.
// Assumes the design package and the far-side model are compiled first.
module test_hppc_top;
   import hppc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;

   localparam logic [7:0] ROMB = 8'h96;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pw = 1'b0;
   logic [7:0]  pa = 8'h00;
   logic [31:0] pd = 32'h0, q;
   logic        e, vbus = 1'b0, strap = 1'b1, dis_n = 1'b1, alert_req = 1'b0;
   logic [3:0]  fault = 4'h0;
   wire  [31:0] prdata;
   wire  [3:0]  ppe, oc, chg;
   wire  [7:0]  rom_rx;
   wire         pready, pslverr, pu, leg, ce_n, sck, mosi, miso, irq, alert_n;
   int          fail_count = 0;
   int          num_checks = 0;

   // --------------------------------------------------------------------
   // Clock, design and far side.
   // --------------------------------------------------------------------
   always #25 clk = ~clk;

   hppc_top dut_u (.I_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(pen),
      .I_PWRITE(pw), .I_PADDR(pa), .I_PWDATA(pd), .O_PRDATA(prdata),
      .O_PREADY(pready), .O_PSLVERR(pslverr), .O_PORT_POWER_ENABLE(ppe),
      .I_OVERCURRENT_SENSE(oc), .O_CHARGE_ACTIVE(chg), .I_BUS_POWER_DETECT(vbus),
      .O_DP_PULLUP_EN(pu), .I_JTAG_RESET_STRAP(strap), .O_LEGACY_MODE(leg),
      .I_CHARGING_DISABLE_N(dis_n), .I_CHARGER_ALERT_N(alert_n),
      .O_ROM_ENABLE_N(ce_n), .O_ROM_CLK(sck), .O_ROM_SERIAL_OUT(mosi),
      .I_ROM_SERIAL_IN(miso), .O_IRQ(irq));

   hppc_partner #(.ROM_BYTE(ROMB)) far_u (.i_ce_n(ce_n), .i_sck(sck), .i_mosi(mosi),
      .i_pwr(ppe), .i_fault(fault), .i_alert_req(alert_req), .o_oc(oc),
      .o_alert_n(alert_n), .o_miso(miso), .o_rx(rom_rx));

   // --------------------------------------------------------------------
   // Shared tasks.
   // --------------------------------------------------------------------
   // Prints the counts and the verdict, then ends the run.
   task report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop

   // Compares one value and counts the outcome.
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         fail_count++;
      end
   endtask : chk

   // Waits some edges, then lets their updates land.
   task cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc

   // One APB transfer; read data and error are taken at the ready edge.
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pen  <= 1'b0;
      pw   <= w;
      pa   <= a;
      pd   <= d;
      @(posedge clk);
      pen <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      pen  <= 1'b0;
      if (pready !== 1'b1)
      begin
         fail_count++;
         report_and_stop();
      end
   endtask : apb

   // Holds reset for sixteen cycles.
   task do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset

   // --------------------------------------------------------------------
   // Scenarios.
   // --------------------------------------------------------------------
   // Reset levels of the outputs and of the control register.
   task t_reset();
      cyc(1);
      chk("power", 32'h0, ppe);
      chk("rom enable", 32'h1, ce_n);
      chk("irq", 32'h0, irq);
      apb(1'b0, ADDR_CTRL, 32'h0);
      chk("ctrl", 32'(CTRL_RST), q);
      $display("test reset done");
   endtask : t_reset

   // Each port alone, then all four together.
   task t_power();
      logic [3:0] v;
      for (int i = 0; i < 5; i++)
      begin
         v = (i < 4) ? 4'(1 << i) : 4'hf;
         apb(1'b1, ADDR_CTRL, 32'(v));
         cyc(2);
         chk("power", 32'(v), ppe);
      end
      $display("test power done");
   endtask : t_power

   // Connect only while bus power is seen, and only after the synchroniser.
   task t_vbus();
      apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_PUEN_BIT);
      cyc(3);
      chk("pullup no vbus", 32'h0, pu);
      @(posedge clk);
      vbus <= 1'b1;
      cyc(1);
      chk("pullup early", 32'h0, pu);
      cyc(4);
      chk("pullup", 32'h1, pu);
      @(posedge clk);
      vbus <= 1'b0;
      cyc(5);
      chk("pullup drop", 32'h0, pu);
      $display("test vbus done");
   endtask : t_vbus

   // Disable input suspends every charging port at once.
   task t_charge();
      apb(1'b1, ADDR_CTRL, 32'h000000a0);
      cyc(3);
      chk("charge", 32'ha, chg);
      @(posedge clk);
      dis_n <= 1'b0;
      cyc(5);
      chk("charge off", 32'h0, chg);
      @(posedge clk);
      dis_n <= 1'b1;
      cyc(5);
      chk("charge back", 32'ha, chg);
      $display("test charge done");
   endtask : t_charge

   // Alert events raise, mask and clear the interrupt; an over-current event sets its status bit.
   task t_irq();
      apb(1'b1, ADDR_IRQ_CLR, 32'hff);
      apb(1'b1, ADDR_IRQ_EN, 32'h21);
      apb(1'b1, ADDR_CTRL, 32'h1);
      @(posedge clk);
      alert_req <= 1'b1;
      cyc(5);
      chk("irq alert", 32'h1, irq);
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("stat alert", 32'h20, q & 32'h21);
      apb(1'b1, ADDR_IRQ_EN, 32'h0);
      cyc(2);
      chk("irq masked", 32'h0, irq);
      @(posedge clk);
      alert_req <= 1'b0;
      apb(1'b1, ADDR_IRQ_CLR, 32'h20);
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("stat cleared", 32'h0, q & 32'h20);
      @(posedge clk);
      fault <= 4'h1;
      cyc(5);
      apb(1'b0, ADDR_IRQ_STAT, 32'h0);
      chk("stat oc", 32'h1, q & 32'hf);
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status oc", 32'h1, q & 32'hf);
      fault <= 4'h0;
      $display("test irq done");
   endtask : t_irq

   // Unmapped address is refused on both directions.
   task t_unmapped();
      apb(1'b0, 8'h1c, 32'h0);
      chk("err read", 32'h1, e);
      chk("data read", 32'h0, q);
      apb(1'b1, 8'h1c, 32'hffffffff);
      chk("err write", 32'h1, e);
      $display("test unmapped done");
   endtask : t_unmapped

   // One byte each way with the serial ROM.
   task t_rom();
      int n;
      apb(1'b1, ADDR_IRQ_CLR, 32'hff);
      apb(1'b1, ADDR_IRQ_EN, 32'h1 << IRQ_ROM_BIT);
      apb(1'b1, ADDR_ROM_CMD, (32'h1 << ROM_GO_BIT) | 32'hc3);
      cyc(2);
      chk("rom enable low", 32'h0, ce_n);
      n = 0;
      while (irq !== 1'b1 && n < 400)
      begin
         cyc(1);
         n++;
      end
      chk("rom done", 32'h1, irq);
      chk("rom got", 32'hc3, rom_rx);
      apb(1'b0, ADDR_ROM_DATA, 32'h0);
      chk("rom data", 32'(ROMB), q & 32'hff);
      chk("rom idle", 32'h2, {ce_n, sck});
      $display("test rom done");
   endtask : t_rom

   // Strap is taken after reset and only counts with SMBus in use.
   task t_strap();
      apb(1'b1, ADDR_CTRL, 32'h0);
      cyc(2);
      chk("legacy off", 32'h0, leg);
      apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_SMB_BIT);
      cyc(2);
      chk("legacy", 32'h1, leg);
      @(posedge clk);
      strap <= 1'b0;
      cyc(3);
      chk("legacy kept", 32'h1, leg);
      do_reset();
      apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_SMB_BIT);
      cyc(2);
      chk("advanced", 32'h0, leg);
      $display("test strap done");
   endtask : t_strap

   // --------------------------------------------------------------------
   // Main sequence and watchdog.
   // --------------------------------------------------------------------
   initial
   begin
      do_reset();
      t_reset();
      t_power();
      t_vbus();
      t_charge();
      t_irq();
      t_unmapped();
      t_rom();
      t_strap();
      report_and_stop();
   end

   // Cuts a hang short.
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
endmodule : test_hppc_top
